// ---- logic/periodic_timer.sv ----
// module: periodic timer core with count-up counter, two comparators and output pin
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
module periodic_timer
  import periodic_timer_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // auxiliary clock ticks, on clk_i
  input  wire logic       high_tick_i,
  input  wire logic       sub_tick_i,
  // pins
  input  wire logic       ext_count_i,
  output logic            timer_output_pin_o,
  output logic            timer_output_pin_n_o,
  output logic            irq_o
);
  // ==========================================================
  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // two-flop release of the asynchronous reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];
  // ==========================================================
  // registers
  logic [7:0]       ctrl0_reg;
  logic [7:0]       ctrl1_reg;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] cmpa_reg;
  logic [CNT_W-1:0] cmpp_reg;
  logic [7:0]       cmpa_buf_reg;
  logic [7:0]       cmpp_buf_reg;
  logic [7:0]       rd_buf_reg;
  logic [1:0]       irq_st_reg;
  logic [1:0]       irq_en_reg;
  logic [7:0]       rdata_reg;
  logic             pin_reg;
  logic             run_d_reg;
  logic [1:0]       presc_reg;
  logic [5:0]       hpresc_reg;
  logic             hold;
  logic             run;
  logic [2:0]       ck_sel;
  logic [1:0]       mode;
  logic [1:0]       pin_act;
  logic             run_rise;
  logic             tick;
  logic             match_a;
  logic             match_p;
  logic             overflow;
  logic             clear_cnt;
  logic             ext_rise;
  logic             ext_fall;
  logic [7:0]       cnt_hi;
  logic [7:0]       cmpa_hi;
  logic [7:0]       cmpp_hi;

  assign hold    = ctrl0_reg[HOLD_BIT];
  assign run     = ctrl0_reg[RUN_BIT];
  assign ck_sel  = ctrl0_reg[CKSEL_MSB:CKSEL_LSB];
  assign mode    = ctrl1_reg[MODE_MSB:MODE_LSB];
  assign pin_act = ctrl1_reg[PINACT_MSB:PINACT_LSB];
  assign run_rise = run && !run_d_reg;

  // ==========================================================
  // external pin synchroniser
  pin_sync u_ext_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .ce_i    (ce_i),
    .pin_i   (ext_count_i),
    .level_o (),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall)
  );

  // prescalers: system cycles and high ticks counted apart, so /16 and /64 follow the high clock
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg  <= 2'h0;
      hpresc_reg <= 6'h00;
    end else if (ce_i) begin
      presc_reg  <= presc_reg + 2'h1;
      hpresc_reg <= hpresc_reg + 6'(high_tick_i);
    end
  end

  // counter clock select
  always_comb begin
    case (ck_sel)
      CK_SYS_DIV4: tick = (presc_reg == 2'(DIV_SYS - 1));
      CK_SYS:      tick = 1'b1;
      CK_HIGH_16:  tick = high_tick_i && (hpresc_reg[3:0] == 4'(DIV_H16 - 1));
      CK_HIGH_64:  tick = high_tick_i && (hpresc_reg == 6'(DIV_H64 - 1));
      CK_SUB_A,
      CK_SUB_B:    tick = sub_tick_i;
      CK_EXT_RISE: tick = ext_rise;
      CK_EXT_FALL: tick = ext_fall;
      default:     tick = 1'b0;
    endcase
  end

  // ==========================================================
  // comparators and clear
  assign match_a   = run && (count_reg == cmpa_reg);
  assign match_p   = run && (count_reg == cmpp_reg) && (cmpp_reg != '0);
  assign overflow  = run && tick && !hold && (&count_reg) && (cmpp_reg == '0);
  assign clear_cnt = ctrl1_reg[CLRSEL_BIT] ? match_a : (match_p || overflow);

  // counter: no software write path
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (ce_i) begin
      if (run_rise) begin
        count_reg <= '0;
      end else if (run && tick && !hold) begin
        if (clear_cnt) begin
          count_reg <= '0;
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

  // run bit delayed for edge detection
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_d_reg <= 1'b0;
    end else if (ce_i) begin
      run_d_reg <= run;
    end
  end

  // ==========================================================
  // output pin control
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_reg <= 1'b0;
    end else if (ce_i) begin
      if (run_rise) begin
        pin_reg <= ctrl1_reg[INITLVL_BIT];
      end else if (mode == MODE_CMP_OUT && match_a && tick && !hold) begin
        case (pin_act)
          ACT_LOW:    pin_reg <= 1'b0;
          ACT_HIGH:   pin_reg <= 1'b1;
          ACT_TOGGLE: pin_reg <= !pin_reg;
          default:    pin_reg <= pin_reg;
        endcase
      end else if (mode == MODE_PWM) begin
        case (pin_act)
          ACT_NONE: pin_reg <= !ctrl1_reg[INITLVL_BIT];
          ACT_LOW:  pin_reg <= ctrl1_reg[INITLVL_BIT];
          default:  pin_reg <= pin_reg;
        endcase
      end
    end
  end

  // output drive with inversion outside timer mode; timer mode drives pin_reg uninverted
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin_o   <= 1'b0;
      timer_output_pin_n_o <= 1'b1;
    end else if (ce_i) begin
      if (mode == MODE_TIMER) begin
        timer_output_pin_o   <= pin_reg;
        timer_output_pin_n_o <= !pin_reg;
      end else begin
        timer_output_pin_o   <= pin_reg ^ ctrl1_reg[INVERT_BIT];
        timer_output_pin_n_o <= !(pin_reg ^ ctrl1_reg[INVERT_BIT]);
      end
    end
  end

  // ==========================================================
  // interrupt status: set wins over clear
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_reg <= 2'h0;
    end else if (ce_i) begin
      for (int i = 0; i < 2; i++) begin
        if (i == IRQ_A_BIT && match_a && tick && !hold) begin
          irq_st_reg[i] <= 1'b1;
        end else if (i == IRQ_P_BIT && (match_p || overflow) && tick && !hold) begin
          irq_st_reg[i] <= 1'b1;
        end else if (wr_i && addr_i == ADDR_IRQ_CLR && wdata_i[i]) begin
          irq_st_reg[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_st_reg & irq_en_reg);
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_reg  <= CTRL0_RST;
      ctrl1_reg  <= CTRL1_RST;
      irq_en_reg <= 2'h0;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        ADDR_CTRL0:  ctrl0_reg  <= wdata_i & CTRL0_MASK;
        ADDR_CTRL1:  ctrl1_reg  <= wdata_i;
        ADDR_IRQ_EN: irq_en_reg <= wdata_i[1:0];
        default:     ctrl0_reg  <= ctrl0_reg;
      endcase
    end
  end

  // compare pairs: low byte waits in a buffer until the high write
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cmpa_reg     <= '0;
      cmpp_reg     <= '0;
      cmpa_buf_reg <= 8'h00;
      cmpp_buf_reg <= 8'h00;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        ADDR_CMPA_LO: cmpa_buf_reg <= wdata_i;
        ADDR_CMPP_LO: cmpp_buf_reg <= wdata_i;
        ADDR_CMPA_HI: cmpa_reg <= CNT_W'({wdata_i, cmpa_buf_reg});
        ADDR_CMPP_HI: cmpp_reg <= CNT_W'({wdata_i, cmpp_buf_reg});
        default:      cmpa_buf_reg <= cmpa_buf_reg;
      endcase
    end
  end

  // ==========================================================
  // register reads: high read latches low byte into a buffer
  assign cnt_hi  = 8'({8'h00, count_reg} >> 8);
  assign cmpa_hi = 8'({8'h00, cmpa_reg} >> 8);
  assign cmpp_hi = 8'({8'h00, cmpp_reg} >> 8);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_buf_reg <= 8'h00;
    end else if (ce_i && rd_i) begin
      case (addr_i)
        ADDR_CNT_HI:  rd_buf_reg <= count_reg[7:0];
        ADDR_CMPA_HI: rd_buf_reg <= cmpa_reg[7:0];
        ADDR_CMPP_HI: rd_buf_reg <= cmpp_reg[7:0];
        default:      rd_buf_reg <= rd_buf_reg;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (ce_i) begin
      rdata_reg <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          ADDR_CTRL0:   rdata_reg <= ctrl0_reg & CTRL0_MASK;
          ADDR_CTRL1:   rdata_reg <= ctrl1_reg;
          ADDR_CNT_LO:  rdata_reg <= rd_buf_reg;
          ADDR_CNT_HI:  rdata_reg <= cnt_hi;
          ADDR_CMPA_LO: rdata_reg <= rd_buf_reg;
          ADDR_CMPA_HI: rdata_reg <= cmpa_hi;
          ADDR_CMPP_LO: rdata_reg <= rd_buf_reg;
          ADDR_CMPP_HI: rdata_reg <= cmpp_hi;
          ADDR_IRQ_ST:  rdata_reg <= {6'h00, irq_st_reg};
          ADDR_IRQ_EN:  rdata_reg <= {6'h00, irq_en_reg};
          default:      rdata_reg <= 8'h00;
        endcase
      end
    end
  end
  assign rdata_o = rdata_reg;

  // ==========================================================
  // checks
  property p_run_rise_zero;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && run_rise) |=> (count_reg == '0);
  endproperty
  a_run_rise_zero: assert property (p_run_rise_zero) else $error("run rise did not zero counter");

  property p_hold_freeze;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && hold && !run_rise) |=> $stable(count_reg);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("counter moved while held");

  property p_off_freeze;
    @(posedge clk_i) disable iff (!rst_n)
    (!run && !run_d_reg) |=> $stable(count_reg);
  endproperty
  a_off_freeze: assert property (p_off_freeze) else $error("counter moved while off");

  property p_clear_match;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !run_rise && run && tick && !hold && clear_cnt) |=> (count_reg == '0);
  endproperty
  a_clear_match: assert property (p_clear_match) else $error("match did not clear counter");

  property p_count_up;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && !run_rise && run && tick && !hold && !clear_cnt)
      |=> (count_reg == $past(count_reg) + 1'b1);
  endproperty
  a_count_up: assert property (p_count_up) else $error("counter did not step");

  property p_flag_a;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && match_a && tick && !hold) |=> irq_st_reg[IRQ_A_BIT] ##1 irq_o || !irq_en_reg[0];
  endproperty
  a_flag_a: assert property (p_flag_a) else $error("A flag not set");

  property p_ctrl0_low;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && rd_i && addr_i == ADDR_CTRL0) |=> (rdata_o[2:0] == 3'h0);
  endproperty
  a_ctrl0_low: assert property (p_ctrl0_low) else $error("reserved bits read nonzero");

  property p_pin_init;
    @(posedge clk_i) disable iff (!rst_n)
    (ce_i && run_rise) |=> (pin_reg == $past(ctrl1_reg[INITLVL_BIT]));
  endproperty
  a_pin_init: assert property (p_pin_init) else $error("pin not at initial level");
endmodule

// ---- logic/periodic_timer_pkg.sv ----
// package: register map, field positions, reset values and clock figures of the periodic timer
package periodic_timer_pkg;
  // register offsets (byte addresses on the plain register port)
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_CTRL1   = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO  = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI  = 4'h3;
  localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
  localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
  localparam logic [3:0] ADDR_CMPP_LO = 4'h6;
  localparam logic [3:0] ADDR_CMPP_HI = 4'h7;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h9;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'hA;
  // control register 0 fields
  localparam int HOLD_BIT    = 7;
  localparam int CKSEL_MSB   = 6;
  localparam int CKSEL_LSB   = 4;
  localparam int RUN_BIT     = 3;
  // control register 1 fields
  localparam int MODE_MSB    = 7;
  localparam int MODE_LSB    = 6;
  localparam int PINACT_MSB  = 5;
  localparam int PINACT_LSB  = 4;
  localparam int INITLVL_BIT = 3;
  localparam int INVERT_BIT  = 2;
  localparam int CLRSEL_BIT  = 0;
  // interrupt status bits
  localparam int IRQ_A_BIT   = 0;
  localparam int IRQ_P_BIT   = 1;
  // reset values and control register 0 writable-bit mask
  localparam logic [7:0] CTRL0_RST   = 8'h00;
  localparam logic [7:0] CTRL1_RST   = 8'h00;
  localparam logic [7:0] CTRL0_MASK  = 8'hF8;
  // clock select codes
  localparam logic [2:0] CK_SYS_DIV4  = 3'h0;
  localparam logic [2:0] CK_SYS       = 3'h1;
  localparam logic [2:0] CK_HIGH_16   = 3'h2;
  localparam logic [2:0] CK_HIGH_64   = 3'h3;
  localparam logic [2:0] CK_SUB_A     = 3'h4;
  localparam logic [2:0] CK_SUB_B     = 3'h5;
  localparam logic [2:0] CK_EXT_RISE  = 3'h6;
  localparam logic [2:0] CK_EXT_FALL  = 3'h7;
  // prescaler divide counts
  localparam int DIV_SYS  = 4;
  localparam int DIV_H16  = 16;
  localparam int DIV_H64  = 64;
  // operating mode codes
  localparam logic [1:0] MODE_CMP_OUT = 2'h0;
  localparam logic [1:0] MODE_UNDEF   = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;
  // pin action codes
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_LOW      = 2'h1;
  localparam logic [1:0] ACT_HIGH     = 2'h2;
  localparam logic [1:0] ACT_TOGGLE   = 2'h3;
  // system clock
  localparam int CLK_HZ = 40_000_000;
endpackage

// ---- logic/pin_sync.sv ----
// module: three-stage input synchroniser with agreement-based edge detection
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // raw pin and results
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic [2:0] stage_reg;
  logic       level_reg;

  // three flip-flops; first stage only feeds the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_reg <= 3'h0;
    end else if (ce_i) begin
      stage_reg <= {stage_reg[1:0], pin_i};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
    end else if (ce_i && (stage_reg[1] == stage_reg[2])) begin
      level_reg <= stage_reg[2];
    end
  end

  assign level_o = level_reg;
  assign rise_o  = ce_i && (stage_reg[1] == stage_reg[2]) && stage_reg[2] && !level_reg;
  assign fall_o  = ce_i && (stage_reg[1] == stage_reg[2]) && !stage_reg[2] && level_reg;
endmodule

// ---- verification/periodic_timer_partner.sv ----
// partner model: external count pin and auxiliary clock ticks seen by the periodic timer
`timescale 1ns/1ps
module periodic_timer_partner (
  // clock
  input  wire logic clk_i,
  // pin and ticks toward the timer
  output logic      ext_count_o,
  output logic      high_tick_o,
  output logic      sub_tick_o
);
  logic [2:0] tick_reg;

  // ==========================================================
  // auxiliary clocks
  // free divider: high clock ticks every 2nd cycle, sub clock every 8th
  initial tick_reg = 3'h0;
  always @(posedge clk_i) begin
    tick_reg <= tick_reg + 3'h1;
  end
  assign high_tick_o = tick_reg[0];
  assign sub_tick_o  = (tick_reg == 3'h7);

  // ==========================================================
  // external count pin
  // the outside source rests low between bursts, so no stray edges appear
  initial ext_count_o = 1'b0;

  // n full pulses, each wide enough for the three-flop synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      ext_count_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_count_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask
endmodule

// ---- verification/periodic_timer_tb.sv ----
// testbench: register port, counting, interrupts and output pin of the periodic timer
`timescale 1ns/1ps
module periodic_timer_tb;
  import periodic_timer_pkg::*;
  // ==========================================================
  // signals, counters and model tables
  logic        clk    = 1'b0;
  logic        arst_n;
  logic        ce;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        pin;
  logic        pin_n;
  logic        irq;
  logic        high_tick;
  logic        sub_tick;
  logic        ext;
  logic [15:0] v;
  logic        init;
  logic        inv;
  logic        lvl;
  int          err_count  = 0;
  int          num_checks = 0;
  int          n;
  int          m;
  int          en;
  // expected counts in 512 cycles per clock select code
  int          rate [6] = '{128, 512, 16, 4, 64, 64};
  // address, write value, read-back value
  logic [19:0] tab  [5] = '{{ADDR_CTRL0, 8'h07, 8'h00}, {ADDR_CTRL1, 8'hFD, 8'hFD},
                            {4'hF, 8'hFF, 8'h00}, {ADDR_IRQ_ST, 8'hFF, 8'h00},
                            {ADDR_IRQ_EN, 8'h02, 8'h02}};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // ==========================================================
  // design and partner
  periodic_timer #(
    .CNT_W (16)
  ) u_periodic_timer (
    .clk_i                (clk),
    .arst_n_i             (arst_n),
    .ce_i                 (ce),
    .addr_i               (addr),
    .wdata_i              (wdata),
    .wr_i                 (wr),
    .rd_i                 (rd),
    .rdata_o              (rdata),
    .high_tick_i          (high_tick),
    .sub_tick_i           (sub_tick),
    .ext_count_i          (ext),
    .timer_output_pin_o   (pin),
    .timer_output_pin_n_o (pin_n),
    .irq_o                (irq)
  );

  periodic_timer_partner u_periodic_timer_partner (
    .clk_i       (clk),
    .ext_count_o (ext),
    .high_tick_o (high_tick),
    .sub_tick_o  (sub_tick)
  );

  // ==========================================================
  // bus cycles and comparisons
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = {8'h00, rdata};
  endtask

  // high byte first, it latches the low byte for the second read
  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    logic [15:0] t;
    rd_reg(a, d);
    rd_reg(a - 4'h1, t);
    d = {d[7:0], t[7:0]};
  endtask

  // low byte first, the high write commits both
  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    wr_reg(a, d[7:0]);
    wr_reg(a + 4'h1, d[15:8]);
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] ex);
    num_checks++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask

  // tolerance covers bus latency and prescaler phase
  task automatic chk_near(input logic [15:0] got, input int ex);
    num_checks++;
    if ((got >= 16'(ex - 3) && got <= 16'(ex + 3)) !== 1'b1) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, 16'(ex));
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // watchdog against a hung handshake or sequence
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    arst_n <= 1'b0;
    ce     <= 1'b1;
    addr   <= 4'h0;
    wdata  <= 8'h00;
    wr     <= 1'b0;
    rd     <= 1'b0;
    void'($urandom(32'hAB8D6CB6));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // reset values, unused bits, unmapped and read-only places
    rd_reg(ADDR_CTRL0, v);
    chk(v, 16'(CTRL0_RST));
    rd_reg(ADDR_CTRL1, v);
    chk(v, 16'(CTRL1_RST));
    for (int k = 0; k < 5; k++) begin
      wr_reg(tab[k][19:16], tab[k][15:8]);
      rd_reg(tab[k][19:16], v);
      chk(v, {8'h00, tab[k][7:0]});
    end
    // compare pair through the low-byte buffer
    wr16(ADDR_CMPA_LO, 16'h1234);
    rd16(ADDR_CMPA_HI, v);
    chk(v, 16'h1234);
    wr_reg(ADDR_CMPA_LO, 8'h99);
    rd16(ADDR_CMPA_HI, v);
    chk(v, 16'h1234);
    n = $urandom_range(65535, 0);
    wr16(ADDR_CMPP_LO, 16'(n));
    rd16(ADDR_CMPP_HI, v);
    chk(v, 16'(n));
    // external edges, clear by A or P match, flags and interrupt masking
    for (int k = 0; k < 4; k++) begin
      m  = $urandom_range(9, 2);
      n  = $urandom_range(25, 12);
      en = (k != 3);
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_CTRL1, {7'h60, k[1]});
      wr16(ADDR_CMPA_LO, k[1] ? 16'(m) : 16'hFFFF);
      wr16(ADDR_CMPP_LO, k[1] ? 16'hFFFF : 16'(m));
      wr_reg(ADDR_IRQ_CLR, 8'h03);
      wr_reg(ADDR_IRQ_EN, en ? 8'h03 : 8'h00);
      wr_reg(ADDR_CTRL0, {3'h3, k[0], 4'h8});
      u_periodic_timer_partner.pulses(n);
      rd16(ADDR_CNT_HI, v);
      chk(v, 16'(n % (m + 1)));
      rd_reg(ADDR_IRQ_ST, v);
      chk(v, k[1] ? 16'h0001 : 16'h0002);
      chk(16'(irq), 16'(en));
      wr_reg(ADDR_IRQ_CLR, 8'h03);
      rd_reg(ADDR_IRQ_ST, v);
      chk(v | 16'(irq), 16'h0000);
    end
    // hold, run fall and rise, counter writes ignored
    wr16(ADDR_CMPA_LO, 16'hFFFF);
    wr_reg(ADDR_CTRL0, 8'h00);
    wr_reg(ADDR_CTRL1, 8'hC1);
    wr_reg(ADDR_CTRL0, 8'h68);
    u_periodic_timer_partner.pulses(5);
    wr_reg(ADDR_CTRL0, 8'hE8);
    u_periodic_timer_partner.pulses(4);
    rd16(ADDR_CNT_HI, v);
    chk(v, 16'd5);
    wr_reg(ADDR_CTRL0, 8'h68);
    u_periodic_timer_partner.pulses(3);
    rd16(ADDR_CNT_HI, v);
    chk(v, 16'd8);
    wr_reg(ADDR_CTRL0, 8'h60);
    u_periodic_timer_partner.pulses(2);
    wr16(ADDR_CNT_LO, 16'h5555);
    rd16(ADDR_CNT_HI, v);
    chk(v, 16'd8);
    wr_reg(ADDR_CTRL0, 8'h68);
    rd16(ADDR_CNT_HI, v);
    chk(v, 16'd0);
    // internal clock sources over a fixed window
    for (int k = 0; k < 6; k++) begin
      wr_reg(ADDR_CTRL0, {1'b0, 3'(k), 4'h0});
      wr_reg(ADDR_CTRL0, {1'b0, 3'(k), 4'h8});
      repeat (512) @(posedge clk);
      wr_reg(ADDR_CTRL0, {1'b1, 3'(k), 4'h8});
      rd16(ADDR_CNT_HI, v);
      chk_near(v, rate[k]);
    end
    // clock enable low for 200 cycles freezes counting: 99 + 102 enabled edges remain
    wr_reg(ADDR_CTRL0, 8'h10);
    wr_reg(ADDR_CTRL0, 8'h18);
    repeat (100) @(posedge clk);
    ce <= 1'b0;
    repeat (200) @(posedge clk);
    ce <= 1'b1;
    repeat (100) @(posedge clk);
    wr_reg(ADDR_CTRL0, 8'h98);
    rd16(ADDR_CNT_HI, v);
    chk_near(v, 201);
    // output pin: initial level, every pin action, invert, forced pwm levels
    wr16(ADDR_CMPA_LO, 16'h0002);
    for (int k = 0; k < 10; k++) begin
      init = k[2];
      inv  = 1'($urandom_range(1, 0));
      wr_reg(ADDR_CTRL0, 8'h00);
      wr_reg(ADDR_CTRL1, {k[3], 1'b0, k[1:0], init, inv, 2'h1});
      wr_reg(ADDR_CTRL0, 8'h68);
      repeat (2) @(posedge clk);
      #1;
      if (k < 8) begin
        chk({pin_n, pin}, {~(init ^ inv), init ^ inv});
        u_periodic_timer_partner.pulses(3);
        lvl = (k[1:0] == 2'h0) ? init : (k[1:0] == 2'h3) ? ~init : k[1];
      end else begin
        repeat (3) @(posedge clk);
        lvl = k[0] ? init : ~init;
      end
      chk({pin_n, pin}, {~(lvl ^ inv), lvl ^ inv});
    end
    stop_test();
  end
endmodule
